// ===== hdl/cec_pkg.sv
// package: constants and an edge-match function for the comparator edge interrupt controller
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package cec_pkg;
    localparam int CEC_NCH = 3;
    localparam int CEC_AW = 12;
    // register byte offsets
    localparam logic [11:0] CEC_OFF_CTRL = 12'h000;
    localparam logic [11:0] CEC_OFF_STAT = 12'h004;
    localparam logic [11:0] CEC_OFF_MASK = 12'h008;
    localparam logic [11:0] CEC_OFF_OUT = 12'h00C;
    // control register fields
    localparam int CEC_F_EN = 0;
    localparam int CEC_F_INV = 1;
    localparam int CEC_F_FLT = 2;
    localparam int CEC_F_EDG = 4;
    localparam logic [5:0] CEC_CTRL_RST = 6'h00;
    // edge_select encodings
    localparam logic [1:0] CEC_EDGE_NONE = 2'h0;
    localparam logic [1:0] CEC_EDGE_RISE = 2'h1;
    localparam logic [1:0] CEC_EDGE_FALL = 2'h2;
    localparam logic [1:0] CEC_EDGE_BOTH = 2'h3;
    // filter sample counts per filter_select code (code 0 = filter bypass)
    localparam logic [3:0] CEC_FLT_N1 = 4'h3;
    localparam logic [3:0] CEC_FLT_N2 = 4'h6;
    localparam logic [3:0] CEC_FLT_N3 = 4'hC;

    function automatic logic cec_edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
        cec_edge_hit = ((sel == CEC_EDGE_RISE || sel == CEC_EDGE_BOTH) && !prev && cur) ||
                       ((sel == CEC_EDGE_FALL || sel == CEC_EDGE_BOTH) && prev && !cur);
    endfunction
endpackage

// ===== hdl/cec_chan_if.sv
// interface: shared control and per-channel level and event bundle between top and channel logic
`timescale 1ns/1ps
interface cec_chan_if;
    logic enable;
    logic invert;
    logic [1:0] filter_select;
    logic [1:0] edge_select;
    logic [cec_pkg::CEC_NCH-1:0] level;
    logic [cec_pkg::CEC_NCH-1:0] edge_pulse;
    modport ctl (output enable, output invert, output filter_select, output edge_select,
                 input level, input edge_pulse);
    modport chan (input enable, input invert, input filter_select, input edge_select,
                  output level, output edge_pulse);
endinterface

// ===== hdl/cec_chan.sv
// module: inversion, digital filter and edge detect for all comparator channels
`timescale 1ns/1ps
module cec_chan #(
    parameter int NCH = cec_pkg::CEC_NCH
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // raw analog comparator results
    input wire logic [NCH-1:0] comparator_output,
    // control and events
    cec_chan_if.chan cif
);
    import cec_pkg::*;

    initial begin
        if (NCH < 1 || NCH > 8) $error("cec_chan: NCH out of range");
    end

    typedef struct packed {
        logic [NCH-1:0] raw;
        logic [NCH-1:0] filt;
        logic [NCH-1:0] prev;
        logic [NCH-1:0][3:0] cnt;
        logic [NCH-1:0] pulse;
    } cec_chan_s;

    cec_chan_s st, next_st;
    logic [3:0] need;
    logic [NCH-1:0] pol;

    always_comb begin
        case (cif.filter_select)
            2'h1: need = CEC_FLT_N1;
            2'h2: need = CEC_FLT_N2;
            2'h3: need = CEC_FLT_N3;
            default: need = 4'h0;
        endcase
    end

    // inversion first, then filter, then edge detection
    always_comb begin
        next_st = st;
        pol = comparator_output ^ {NCH{cif.invert}};
        for (int i = 0; i < NCH; i++) begin
            next_st.raw[i] = pol[i];
            if (!cif.enable) begin
                next_st.cnt[i] = 4'h0;
                next_st.filt[i] = 1'b0;
            end else if (need == 4'h0) begin
                next_st.filt[i] = pol[i];
            end else if (pol[i] != st.raw[i]) begin
                next_st.cnt[i] = 4'h0;
            end else if (st.cnt[i] + 4'h1 >= need) begin
                next_st.filt[i] = st.raw[i];
                next_st.cnt[i] = need;
            end else begin
                next_st.cnt[i] = st.cnt[i] + 4'h1;
            end
            next_st.prev[i] = st.filt[i];
            next_st.pulse[i] = cif.enable && cec_edge_hit(cif.edge_select, st.prev[i], st.filt[i]);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cif.level = st.filt;
    assign cif.edge_pulse = st.pulse;

    rise_pulse_a: assert property (@(posedge clk) disable iff (srst)
        (cif.enable && cif.edge_select == CEC_EDGE_RISE && !st.prev[0] && st.filt[0]) |=> st.pulse[0])
        else $error("rising edge gave no pulse");
    // a pulse only ever follows one change of the registered filtered level
    one_cycle_a: assert property (@(posedge clk) disable iff (srst)
        st.pulse[0] |-> st.prev[0] != $past(st.prev[0]))
        else $error("edge pulse without a filtered level change");
    none_sel_a: assert property (@(posedge clk) disable iff (srst)
        (cif.edge_select == CEC_EDGE_NONE) |=> !st.pulse[0])
        else $error("pulse with no edge selected");
    stop_off_a: assert property (@(posedge clk) disable iff (srst)
        !cif.enable |=> !st.filt[0] && !st.pulse[0])
        else $error("comparator active while disabled");
    bypass_a: assert property (@(posedge clk) disable iff (srst)
        (cif.enable && cif.filter_select == 2'h0) |=> st.filt[0] == $past(pol[0]))
        else $error("bypass path not following inverted input");
endmodule

// ===== hdl/cec_top.sv
// module: comparator edge interrupt controller top with apb registers
`timescale 1ns/1ps
module cec_top #(
    parameter int NCH = cec_pkg::CEC_NCH
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cec_pkg::CEC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog comparator side
    input wire logic [NCH-1:0] comparator_output,
    output logic comparator_enable,
    // interrupt
    output logic irq
);
    import cec_pkg::*;

    initial begin
        if (NCH < 1 || NCH > 8) $error("cec_top: NCH out of range");
    end

    typedef struct packed {
        logic [5:0] ctrl;
        logic [NCH-1:0] stat;
        logic [NCH-1:0] mask;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic en;
        logic irq;
    } cec_top_s;

    cec_top_s st, next_st;
    cec_chan_if cif();

    // --------------------------------------------------------------
    // channel processing
    // --------------------------------------------------------------
    cec_chan #(.NCH(NCH)) u_chan (
        .clk(clk),
        .srst(srst),
        .comparator_output(comparator_output),
        .cif(cif)
    );

    assign cif.enable = st.ctrl[CEC_F_EN];
    assign cif.invert = st.ctrl[CEC_F_INV];
    assign cif.filter_select = st.ctrl[CEC_F_FLT +: 2];
    assign cif.edge_select = st.ctrl[CEC_F_EDG +: 2];

    function automatic logic hit(input logic [CEC_AW-1:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // --------------------------------------------------------------
    // register file and interrupt logic
    // --------------------------------------------------------------
    logic setup, wr, rd, mapped, clr_stat;
    always_comb begin
        next_st = st;
        setup = psel && !penable && !st.ready;
        wr = setup && pwrite;
        rd = setup && !pwrite;
        mapped = hit(paddr, CEC_OFF_CTRL) || hit(paddr, CEC_OFF_STAT) ||
                 hit(paddr, CEC_OFF_MASK) || hit(paddr, CEC_OFF_OUT);
        clr_stat = rd && hit(paddr, CEC_OFF_STAT);
        next_st.ready = setup;
        next_st.err = setup && !mapped;
        next_st.rdata = 32'h0000_0000;
        if (rd) begin
            if (hit(paddr, CEC_OFF_CTRL)) next_st.rdata[5:0] = st.ctrl;
            if (hit(paddr, CEC_OFF_STAT)) next_st.rdata[NCH-1:0] = st.stat;
            if (hit(paddr, CEC_OFF_MASK)) next_st.rdata[NCH-1:0] = st.mask;
            if (hit(paddr, CEC_OFF_OUT)) next_st.rdata[NCH-1:0] = cif.level;
        end
        if (wr && pstrb[0]) begin
            if (hit(paddr, CEC_OFF_CTRL)) next_st.ctrl = pwdata[5:0];
            if (hit(paddr, CEC_OFF_MASK)) next_st.mask = pwdata[NCH-1:0];
        end
        // set wins over the read clear
        next_st.stat = (clr_stat ? '0 : st.stat) | cif.edge_pulse;
        next_st.en = next_st.ctrl[CEC_F_EN];
        next_st.irq = |(next_st.stat & next_st.mask);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
            st.ctrl <= CEC_CTRL_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.err;
    assign comparator_enable = st.en;
    assign irq = st.irq;

    sticky_set_a: assert property (@(posedge clk) disable iff (srst)
        cif.edge_pulse[0] |=> st.stat[0])
        else $error("edge event not latched");
    // an unmasked event raises the interrupt; checked only when no apb write is in its setup cycle
    irq_level_a: assert property (@(posedge clk) disable iff (srst)
        (cif.edge_pulse[0] && st.mask[0] && !wr) |=> irq)
        else $error("unmasked event gave no interrupt");
    enable_out_a: assert property (@(posedge clk) disable iff (srst)
        (wr && pstrb[0] && hit(paddr, CEC_OFF_CTRL)) |=> comparator_enable == $past(pwdata[CEC_F_EN]))
        else $error("enable bit not applied");
    apb_ready_a: assert property (@(posedge clk) disable iff (srst)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
endmodule

// ===== tb/cec_top_bench.sv
// testbench: register, edge, filter, mask and enable checks of the comparator controller
`timescale 1ns/1ps
module cec_top_bench;
    import cec_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [2:0] cmp_in = 3'h0;
    logic [31:0] prdata;
    logic pready, pslverr, comparator_enable, irq;
    integer fail_count = 0;
    integer checked = 0;
    integer seed = 77;
    integer e, v, f, i;
    logic [31:0] rd;
    logic err;
    logic [2:0] d;
    int flt_n[4] = '{0, 3, 6, 12};

    cec_top u_cec_top (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_output(cmp_in), .comparator_enable(comparator_enable), .irq(irq));

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never reassigns psel in this time step
        @(posedge clk);
    endtask

    function automatic logic [31:0] ctrl(int eg, int fs, int inv, int en);
        return (eg << 4) | (fs << 2) | (inv << 1) | en;
    endfunction

    function automatic logic hit(int eg, logic p, logic c);
        return ((eg == 1 || eg == 3) && !p && c) || ((eg == 2 || eg == 3) && p && !c);
    endfunction

    task automatic summarize;
        if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        tick(3);
        srst <= 1'b0;
        tick(1);
        for (i = 0; i < 4; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(rd, 32'h0);
            chk(err, 32'h0);
        end
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, CEC_OFF_MASK, 32'h7);
        apb(1'b0, CEC_OFF_MASK, 32'h0);
        chk(rd, 32'h7);
        for (e = 0; e < 4; e++) begin
            for (v = 0; v < 2; v++) begin
                d = 3'($random(seed));
                if (d == 3'h0) d = 3'h5;
                cmp_in <= 3'h0;
                apb(1'b1, CEC_OFF_CTRL, 32'h0);
                tick(8);
                apb(1'b1, CEC_OFF_CTRL, ctrl(e, 0, v, 1));
                tick(20);
                apb(1'b0, CEC_OFF_STAT, 32'h0);
                chk(comparator_enable, 32'h1);
                apb(1'b0, CEC_OFF_CTRL, 32'h0);
                chk(rd, ctrl(e, 0, v, 1));
                cmp_in <= d;
                tick(12);
                chk(irq, hit(e, v, !v));
                apb(1'b0, CEC_OFF_STAT, 32'h0);
                chk(rd, hit(e, v, !v) ? d : 3'h0);
                apb(1'b0, CEC_OFF_OUT, 32'h0);
                chk(rd, d ^ {3{v[0]}});
                cmp_in <= 3'h0;
                tick(12);
                apb(1'b0, CEC_OFF_STAT, 32'h0);
                chk(rd, hit(e, !v, v) ? d : 3'h0);
                tick(2);
                chk(irq, 32'h0);
            end
        end
        for (f = 1; f < 4; f++) begin
            cmp_in <= 3'h0;
            apb(1'b1, CEC_OFF_CTRL, ctrl(1, f, 0, 1));
            tick(30);
            apb(1'b0, CEC_OFF_STAT, 32'h0);
            cmp_in <= 3'h7;
            tick(flt_n[f] - 1);
            cmp_in <= 3'h0;
            tick(30);
            apb(1'b0, CEC_OFF_STAT, 32'h0);
            chk(rd, 32'h0);
            cmp_in <= 3'h7;
            tick(flt_n[f] + 12);
            apb(1'b0, CEC_OFF_STAT, 32'h0);
            chk(rd, 32'h7);
        end
        // masked event keeps status but no interrupt
        apb(1'b1, CEC_OFF_MASK, 32'h0);
        cmp_in <= 3'h0;
        apb(1'b1, CEC_OFF_CTRL, ctrl(1, 0, 0, 1));
        tick(12);
        apb(1'b0, CEC_OFF_STAT, 32'h0);
        cmp_in <= 3'h7;
        tick(12);
        chk(irq, 32'h0);
        apb(1'b0, CEC_OFF_STAT, 32'h0);
        chk(rd, 32'h7);
        // a write with lane 0 disabled leaves the control word alone
        pstrb <= 4'h0;
        apb(1'b1, CEC_OFF_CTRL, 32'h0);
        pstrb <= 4'hF;
        apb(1'b0, CEC_OFF_CTRL, 32'h0);
        chk(rd, ctrl(1, 0, 0, 1));
        apb(1'b1, CEC_OFF_CTRL, ctrl(3, 0, 0, 0));
        tick(12);
        apb(1'b0, CEC_OFF_STAT, 32'h0);
        chk(comparator_enable, 32'h0);
        cmp_in <= 3'h0;
        tick(12);
        cmp_in <= 3'h7;
        tick(12);
        apb(1'b0, CEC_OFF_STAT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, CEC_OFF_OUT, 32'h0);
        chk(rd, 32'h0);
        summarize();
    end

    initial begin
        #80000;
        fail_count++;
        summarize();
    end
endmodule
